// [rtl/wiper_cmd_pkg.sv]
// Purpose: Shared constants and types for the dual wiper serial command decoder.
// Assumes: 16-bit command frames, upper nibble instruction, next nibble address.
// Notes: Nonvolatile cells are modelled as flip-flops with fixed reset contents.
package wiper_cmd_pkg;
	localparam int FRAME_BITS = 16;
	localparam int BIT_COUNT_WIDTH = 4;
	localparam logic [3:0] LAST_BIT = 4'hF;
	localparam logic [3:0] INSTR_NOP = 4'h0;
	localparam logic [3:0] INSTR_SAVE_WIPER = 4'h2;
	localparam logic [3:0] INSTR_STORE_USER = 4'h3;
	localparam logic [3:0] INSTR_READ_STORE = 4'h9;
	localparam logic [3:0] INSTR_LOAD_WIPER = 4'hB;
	localparam logic [3:0] INSTR_SHIFT_LEFT = 4'hC;
	localparam logic [3:0] INSTR_INCREMENT = 4'hE;
	localparam logic [3:0] ADDR_WIPER_ONE = 4'h0;
	localparam logic [3:0] ADDR_WIPER_TWO = 4'h1;
	localparam int STORE_DEPTH = 16;
	localparam logic [7:0] STORE_RESET_VALUE = 8'h80;
	localparam logic [7:0] WIPER_RESET_VALUE = 8'h80;
	localparam logic [15:0] OUT_WORD_RESET = 16'h0000;

	typedef struct packed {
		logic [3:0] instr;
		logic [3:0] addr;
		logic [7:0] data;
	} command_word_t;

	typedef struct packed {
		logic frame_done;
		command_word_t word;
	} frame_t;
endpackage

// [rtl/frame_shifter.sv]
// Purpose: Shifts 16-bit serial frames in and out, most significant bit first.
// Assumes: Serial clock is sampled synchronously; chip select is active low.
// Notes: A frame cut short by chip select is discarded; bits after the sixteenth are ignored.
`timescale 1ns/100ps
`default_nettype none
module frame_shifter
	import wiper_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic [15:0] load_word_i,
	output logic sdo_o,
	output var frame_t frame_o
);
	logic sclk_prev_reg, sclk_prev_next;
	logic [BIT_COUNT_WIDTH-1:0] count_reg, count_next;
	logic [15:0] in_reg, in_next;
	logic [15:0] out_reg, out_next;
	frame_t frame_reg, frame_next;
	logic full_reg, full_next;

	always_comb begin
		sclk_prev_next = sclk_i;
		count_next = count_reg;
		in_next = in_reg;
		out_next = out_reg;
		frame_next = frame_reg;
		frame_next.frame_done = 1'b0;
		full_next = full_reg;
		if (cs_n_i) begin
			count_next = '0;
			full_next = 1'b0;
			out_next = load_word_i;
		end else if (sclk_i && !sclk_prev_reg && !full_reg) begin
			in_next = {in_reg[14:0], sdi_i}; // RULE_12
			count_next = count_reg + 4'h1;
			if (count_reg == LAST_BIT) begin
				full_next = 1'b1; // RULE_12
				frame_next.frame_done = 1'b1; // RULE_12
				frame_next.word = {in_reg[14:0], sdi_i};
			end
		end else if (!sclk_i && sclk_prev_reg && count_reg != 4'h0) begin
			out_next = {out_reg[14:0], 1'b0};
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_prev_reg <= 1'b0;
			count_reg <= '0;
			in_reg <= 16'h0000;
			out_reg <= OUT_WORD_RESET;
			frame_reg <= '0;
			full_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_prev_next;
			count_reg <= count_next;
			in_reg <= in_next;
			out_reg <= out_next;
			frame_reg <= frame_next;
			full_reg <= full_next;
		end
	end

	assign sdo_o = out_reg[15];
	assign frame_o = frame_reg;
endmodule
`default_nettype wire

// [rtl/dual_wiper_serial_command_decoder.sv]
// Purpose: Decodes serial command frames for a dual-channel nonvolatile digital resistor.
// Assumes: Serial pins are synchronous to clock_i; sclk is slower than clock_i / 2.
// Notes: Nonvolatile store is flip-flops; location 0 and 1 back the two wipers.
// Operation
// [RULE_01] Instruction C address 1 doubles wiper two by shifting left one bit.
// [RULE_02] Store frame 0x3280 writes 0x80 into spare location one.
// [RULE_03] Store address field selects the spare location; 0x3340 writes location two.
// [RULE_04] Read frame 0x94XX stages spare location three for the next frame.
// [RULE_05] Next frame shifts out sixteen bits ending with the staged byte.
// [RULE_06] Instruction zero changes nothing, still shifts out, returns to idle.
// [RULE_07] Write protect low blocks every change to the wiper settings; the code still lets a preset strobe reload both wipers.
// [RULE_08] Preset strobe reloads both wipers from their nonvolatile copies.
// [RULE_09] Upper byte B0 or B1 loads the data byte into wiper one or two.
// [RULE_10] Frame 0xE0XX increments wiper one by one.
// [RULE_11] Frame 0x20XX saves wiper one into nonvolatile location zero.
// [RULE_12] Frames are sixteen bits MSB first; output carries the previous frame's word.
`timescale 1ns/100ps
`default_nettype none
module dual_wiper_serial_command_decoder
	import wiper_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic write_protect_n_i,
	input wire logic preset_strobe_n_i,
	output logic sdo_o,
	output logic [7:0] wiper_setting_one_o,
	output logic [7:0] wiper_setting_two_o,
	output logic active_o
);
	typedef enum logic [0:0] {ST_IDLE, ST_ACTIVE} power_state_t;

	frame_t frame;
	command_word_t cmd;
	logic shift_sdo;
	logic preset_fall;
	logic [7:0] wiper_one_reg, wiper_one_next;
	logic [7:0] wiper_two_reg, wiper_two_next;
	logic [7:0] store_reg [STORE_DEPTH];
	logic [7:0] store_next [STORE_DEPTH];
	logic [15:0] out_word_reg, out_word_next;
	logic preset_prev_reg, preset_prev_next;
	logic sdo_reg, sdo_next;
	logic active_reg, active_next;
	power_state_t state_reg, state_next;

	// Next value of one wiper after a completed frame; write protect gates every change.
	function automatic logic [7:0] wiper_update(input command_word_t word,
		input logic [3:0] own_addr, input logic [7:0] current, input logic unlocked);
		wiper_update = current;
		if (unlocked && word.addr == own_addr) begin // RULE_07
			case (word.instr)
				INSTR_LOAD_WIPER: begin
					wiper_update = word.data; // RULE_09
				end
				INSTR_SHIFT_LEFT: begin
					wiper_update = {current[6:0], 1'b0}; // RULE_01
				end
				INSTR_INCREMENT: begin
					if (current != 8'hFF) begin
						wiper_update = current + 8'h01; // RULE_10
					end
				end
				default: begin
					wiper_update = current;
				end
			endcase
		end
	endfunction

	// The shifter hands over one frame per chip-select assertion and sends back out_word_reg.
	frame_shifter u_shifter (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.sdi_i(sdi_i),
		.load_word_i(out_word_reg),
		.sdo_o(shift_sdo),
		.frame_o(frame)
	);

	// The command fields are only meaningful while frame_done is high.
	assign cmd = frame.word;
	assign preset_fall = !preset_strobe_n_i && preset_prev_reg;

	// Pin history: preset level for edge detection and the extra sdo stage.
	always_comb begin
		preset_prev_next = preset_strobe_n_i;
		sdo_next = shift_sdo;
	end

	// The preset history resets high, the idle level of the pin, so reset gives no false reload.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			preset_prev_reg <= 1'b1;
			sdo_reg <= 1'b0;
		end else begin
			preset_prev_reg <= preset_prev_next;
			sdo_reg <= sdo_next;
		end
	end

	// Preset is applied after the frame so that a reload wins over a same-cycle command.
	always_comb begin
		wiper_one_next = wiper_one_reg;
		wiper_two_next = wiper_two_reg;
		if (frame.frame_done) begin
			wiper_one_next = wiper_update(cmd, ADDR_WIPER_ONE, wiper_one_reg,
				write_protect_n_i);
			wiper_two_next = wiper_update(cmd, ADDR_WIPER_TWO, wiper_two_reg,
				write_protect_n_i);
		end
		if (preset_fall) begin
			wiper_one_next = store_reg[ADDR_WIPER_ONE]; // RULE_08
			wiper_two_next = store_reg[ADDR_WIPER_TWO]; // RULE_08
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wiper_one_reg <= WIPER_RESET_VALUE;
			wiper_two_reg <= WIPER_RESET_VALUE;
		end else begin
			wiper_one_reg <= wiper_one_next;
			wiper_two_reg <= wiper_two_next;
		end
	end

	// Indexes 0 and 1 hold the wiper copies; the spare user bytes start at index 2.
	always_comb begin
		store_next = store_reg;
		if (frame.frame_done) begin
			case (cmd.instr)
				INSTR_SAVE_WIPER: begin
					if (cmd.addr[0]) begin
						store_next[ADDR_WIPER_TWO] = wiper_two_reg;
					end else begin
						store_next[ADDR_WIPER_ONE] = wiper_one_reg; // RULE_11
					end
				end
				INSTR_STORE_USER: begin
					store_next[cmd.addr] = cmd.data; // RULE_02 RULE_03
				end
				default: begin
					store_next = store_reg;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < STORE_DEPTH; i++) begin
				store_reg[i] <= STORE_RESET_VALUE;
			end
		end else begin
			store_reg <= store_next;
		end
	end

	// A read command stages the stored byte instead of echoing its own word.
	always_comb begin
		out_word_next = out_word_reg;
		if (frame.frame_done) begin
			if (cmd.instr == INSTR_READ_STORE) begin
				out_word_next = {8'h00, store_reg[cmd.addr]}; // RULE_04 RULE_05
			end else begin
				out_word_next = frame.word; // RULE_12
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			out_word_reg <= OUT_WORD_RESET;
		end else begin
			out_word_reg <= out_word_next;
		end
	end

	// Only a no-op drops back to idle; unknown instructions leave the state alone.
	always_comb begin
		state_next = state_reg;
		if (frame.frame_done) begin
			case (cmd.instr)
				INSTR_NOP: begin
					state_next = ST_IDLE; // RULE_06
				end
				INSTR_SAVE_WIPER, INSTR_STORE_USER, INSTR_READ_STORE: begin
					state_next = ST_ACTIVE;
				end
				INSTR_LOAD_WIPER, INSTR_SHIFT_LEFT, INSTR_INCREMENT: begin
					state_next = ST_ACTIVE;
				end
				default: begin
					state_next = state_reg;
				end
			endcase
		end
		active_next = (state_next == ST_ACTIVE);
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			active_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			active_reg <= active_next;
		end
	end

	assign sdo_o = sdo_reg;
	assign wiper_setting_one_o = wiper_one_reg;
	assign wiper_setting_two_o = wiper_two_reg;
	assign active_o = active_reg;
endmodule
`default_nettype wire

// [verif/dual_wiper_chk.sv]
// Purpose: Port checker for the dual wiper serial command decoder.
// Assumes: Host keeps chip select high between frames and holds strobes for several clocks.
// Notes: Attached by bind after the module.
`timescale 1ns/100ps
`default_nettype none
module dual_wiper_chk
	import wiper_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdi_i,
	input wire logic write_protect_n_i,
	input wire logic preset_strobe_n_i,
	input wire logic sdo_o,
	input wire logic [7:0] wiper_setting_one_o,
	input wire logic [7:0] wiper_setting_two_o,
	input wire logic active_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence quiet4;
		(cs_n_i && preset_strobe_n_i)[*4];
	endsequence
	sequence locked4;
		(!write_protect_n_i && preset_strobe_n_i)[*4];
	endsequence
	sequence steady3;
		(!cs_n_i && $stable(sclk_i))[*3];
	endsequence
	wp_one_a: assert property (locked4 |-> $stable(wiper_setting_one_o))
		else $error("wiper one moved while locked");
	wp_two_a: assert property (locked4 |-> $stable(wiper_setting_two_o))
		else $error("wiper two moved while locked");
	idle_one_a: assert property (quiet4 |-> $stable(wiper_setting_one_o))
		else $error("wiper one moved between frames");
	idle_two_a: assert property (quiet4 |-> $stable(wiper_setting_two_o))
		else $error("wiper two moved between frames");
	sdo_steady_a: assert property (steady3 |-> $stable(sdo_o))
		else $error("serial output moved without a clock edge");
	active_hold_a: assert property (quiet4 |-> $stable(active_o))
		else $error("activity changed between frames");
	active_rise_a: assert property ($rose(active_o) |-> !cs_n_i)
		else $error("activity rose outside a frame");
	reset_state_a: assert property ($fell(rst_i) |-> !active_o &&
		wiper_setting_one_o == WIPER_RESET_VALUE && wiper_setting_two_o == WIPER_RESET_VALUE)
		else $error("wrong state after reset");
endmodule
bind dual_wiper_serial_command_decoder dual_wiper_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
	.sclk_i(sclk_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i), .write_protect_n_i(write_protect_n_i),
	.preset_strobe_n_i(preset_strobe_n_i), .sdo_o(sdo_o), .active_o(active_o),
	.wiper_setting_one_o(wiper_setting_one_o), .wiper_setting_two_o(wiper_setting_two_o));
`default_nettype wire

// [verif/spi_host_model.sv]
// Purpose: Serial host that shifts one 16-bit frame and captures the returned word.
// Assumes: Caller enters xfer just after a rising clock edge.
// Notes: Serial clock stands low outside frames; data in is inverted once released.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input wire logic clock_i,
	input wire logic sdo_i,
	output var logic sclk_o,
	output var logic cs_n_o,
	output var logic sdi_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_o <= w[i];
			repeat (4) @(posedge clock_i);
			@(negedge clock_i) r[i] = sdo_i;
			@(posedge clock_i) sclk_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clock_i);
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (4) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// [verif/dual_wiper_serial_command_decoder_bench.sv]
// Purpose: Self-checking bench for the dual wiper serial command decoder.
// Assumes: Out word of each frame is the previous frame's word or a staged readback.
// Notes: Expected words are queued and compared with the returned word by a watcher process.
`timescale 1ns/100ps
`default_nettype none
module dual_wiper_serial_command_decoder_bench;
	logic clock_i, rst_i, sclk, cs_n, sdi, wp_n, pr_n, sdo, act;
	logic [7:0] w1, w2;
	logic [15:0] prev, seen;
	logic [15:0] exp_q[$];
	int err_count, total_checks;
	event got;
	dual_wiper_serial_command_decoder uut (.clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk),
		.cs_n_i(cs_n), .sdi_i(sdi), .write_protect_n_i(wp_n), .preset_strobe_n_i(pr_n),
		.sdo_o(sdo), .wiper_setting_one_o(w1), .wiper_setting_two_o(w2), .active_o(act));
	spi_host_model u_host (.clock_i(clock_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n),
		.sdi_o(sdi));
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task send(input logic [15:0] w, input logic [7:0] e1, e2, input logic [15:0] nxt);
		exp_q.push_back(prev);
		u_host.xfer(w, seen);
		-> got;
		check("wiper one", {8'h00, w1}, {8'h00, e1});
		check("wiper two", {8'h00, w2}, {8'h00, e2});
		check("active", {15'h0000, act}, {15'h0000, |w[15:12]});
		prev = nxt;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial forever begin
		@(got);
		check("sdo word", seen, exp_q.pop_front());
	end
	initial begin
		#300000;
		err_count++;
		complete_run();
	end
	initial begin
		logic [31:0] r;
		void'($urandom(32'h5F53220D));
		{rst_i, wp_n, pr_n, prev} = {3'b111, 16'h0000};
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		send(16'hB140, 8'h80, 8'h40, 16'hB140);
		send(16'hB080, 8'h80, 8'h40, 16'hB080);
		send(16'hC1FF, 8'h80, 8'h80, 16'hC1FF);
		send(16'hC100, 8'h80, 8'h00, 16'hC100);
		send(16'h3255, 8'h80, 8'h00, 16'h3255);
		send(16'h3280, 8'h80, 8'h00, 16'h3280);
		send(16'h3340, 8'h80, 8'h00, 16'h3340);
		send(16'h9400, 8'h80, 8'h00, 16'h0080);
		send(16'h9200, 8'h80, 8'h00, 16'h0080);
		send(16'h9300, 8'h80, 8'h00, 16'h0040);
		send(16'h0000, 8'h80, 8'h00, 16'h0000);
		send(16'hE000, 8'h81, 8'h00, 16'hE000);
		send(16'h2000, 8'h81, 8'h00, 16'h2000);
		send(16'hB005, 8'h05, 8'h00, 16'hB005);
		pr_n <= 1'b0;
		repeat (4) @(posedge clock_i);
		pr_n <= 1'b1;
		repeat (4) @(posedge clock_i);
		wp_n <= 1'b0;
		send(16'hB033, 8'h81, 8'h80, 16'hB033);
		send(16'hC100, 8'h81, 8'h80, 16'hC100);
		wp_n <= 1'b1;
		repeat (3) begin
			r = $urandom;
			send({8'hB0, r[7:0]}, r[7:0], 8'h80, {8'hB0, r[7:0]});
		end
		send(16'hE100, r[7:0], 8'h81, 16'hE100);
		send(16'hC000, {r[6:0], 1'b0}, 8'h81, 16'hC000);
		complete_run();
	end
endmodule
`default_nettype wire
